//--- agu_map.vh
// Constants for the data address generation unit
`ifndef ADDR_GEN_MAP_VH
`define ADDR_GEN_MAP_VH
// APB register byte offsets
`define OFS_READ_PAGE 12'h000
`define OFS_WRITE_PAGE 12'h004
`define OFS_X_MOD_CTRL 12'h008
`define OFS_X_START 12'h00C
`define OFS_X_END 12'h010
`define OFS_Y_MOD_CTRL 12'h014
`define OFS_Y_START 12'h018
`define OFS_Y_END 12'h01C
`define OFS_WREG_BASE 12'h040
`define OFS_WREG_LAST 12'h07C
`define OFS_STATUS 12'h080
`define OFS_PROGRAM_WINDOW_CTRL 12'h084
// Reset values
`define RST_READ_PAGE 10'h001
`define RST_WRITE_PAGE 9'h001
`define RST_STACK 16'h1000
// Mod control fields: bit 15 enable, bits 3:0 register select
`define MOD_EN_BIT 15
// Addressing modes
`define AM_INHERENT 3'h0
`define AM_RELATIVE 3'h1
`define AM_LITERAL 3'h2
`define AM_DIRECT 3'h3
`define AM_REGDIRECT 3'h4
`define AM_INDIRECT 3'h5
// Indirect modifier kinds
`define MOD_NONE 3'h0
`define MOD_POSTINC 3'h1
`define MOD_POSTDEC 3'h2
`define MOD_PREINC 3'h3
`define MOD_PREDEC 3'h4
`define MOD_OFFSET 3'h5
// Base data space limit: 4K words, 8 Kbytes
`define BASE_BYTES 17'h02000
`endif

//--- modulo_corrector.v
// Circular buffer boundary correction for one address generator
`timescale 1ns/1ps
module modulo_corrector #(
  parameter AW = 16
) (
  input wire enable_i,
  input wire decrement_i,
  input wire [AW-1:0] start_i,
  input wire [AW-1:0] end_i,
  input wire [AW-1:0] addr_i,
  output reg [AW-1:0] addr_o,
  output reg wrapped_o
);
  wire [AW:0] span = {1'b0, end_i} - {1'b0, start_i} + {{AW{1'b0}}, 1'b1};

  // Beyond-boundary compare, so strides larger than one word still wrap
  always @* begin
    addr_o = addr_i;
    wrapped_o = 1'b0;
    if (enable_i && !decrement_i && addr_i > end_i) begin
      addr_o = addr_i - span[AW-1:0];
      wrapped_o = 1'b1;
    end else if (enable_i && decrement_i && addr_i < start_i) begin
      addr_o = addr_i + span[AW-1:0];
      wrapped_o = 1'b1;
    end
  end
endmodule

//--- page_mapper.v
// Extends a 16-bit effective address to the 24-bit paged space
`timescale 1ns/1ps
module page_mapper (
  input wire [15:0] ea_i,
  input wire is_write_i,
  input wire [9:0] data_read_page_i,
  input wire [8:0] data_write_page_i,
  output reg [23:0] addr_o,
  output reg program_space_window_o
);
  // Read page bit 9 set selects the program space window instead
  always @* begin
    addr_o = {8'h00, ea_i};
    program_space_window_o = 1'b0;
    if (ea_i[15]) begin
      if (is_write_i) begin
        addr_o = {data_write_page_i[8:0], ea_i[14:0]};
      end else if (!data_read_page_i[9]) begin
        addr_o = {data_read_page_i[8:0], ea_i[14:0]};
      end else begin
        addr_o = {data_read_page_i[8:0], ea_i[14:0]};
        program_space_window_o = 1'b1;
      end
    end
  end
endmodule

//--- data_address_generation_unit.v
// Top of the X and Y data address generators with paging and APB access
`timescale 1ns/1ps
`include "agu_map.vh"
// Notes on behaviour
// - Base data space is 4K words, split into X and Y blocks with own generators
// - Controller-class instructions address only through the X generator, with the same circular correction
// - Signal-processing dual reads use X and Y generators together
// - Upper 32 Kbytes may map to program space at any 16K word boundary
// - Extended data space reaches 8M words, 16 Mbytes
// - Read page register is 10 bits, write page register 9 bits
// - Read page bit 9 clear and EA bit 15 set: page over EA 14:0
// - EA bit 15 set on write: write page over EA 14:0
// - Circular correction is available on any working register, X and Y
// - Increment checks upper bound, decrement lower bound, beyond bound wraps
// - Corrected address written back only for pre or post modify
// - Register-plus-offset is corrected but pointer stays unchanged
// - X circular addressing works for both instruction classes, in indirect mode only
// - Sixteen 16-bit working registers; the last one is the stack pointer
// - Each instruction uses a mode group of at most six modes
module data_address_generation_unit #(
  parameter NREG = 16
) (
  input wire clock_i,
  input wire rstn_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire pready_o,
  output reg [31:0] prdata_o,
  output wire pslverr_o,
  input wire x_req_i,
  input wire x_write_i,
  input wire x_dsp_class_i,
  input wire [2:0] x_mode_i,
  input wire [2:0] x_modifier_i,
  input wire [3:0] x_reg_i,
  input wire [3:0] x_offset_reg_i,
  input wire [15:0] x_literal_i,
  input wire x_byte_i,
  input wire y_req_i,
  input wire [2:0] y_modifier_i,
  input wire [3:0] y_reg_i,
  input wire stack_push_i,
  input wire stack_pop_i,
  input wire wreg_we_i,
  input wire [3:0] wreg_sel_i,
  input wire [15:0] wreg_data_i,
  output reg x_valid_o,
  output reg x_write_o,
  output reg [23:0] x_addr_o,
  output reg x_program_space_o,
  output reg y_valid_o,
  output reg [15:0] y_addr_o,
  output reg mode_error_o
);
  reg [15:0] wreg [0:NREG-1];
  reg [9:0] data_read_page;
  reg [8:0] data_write_page;
  reg [15:0] x_mod_ctrl;
  reg [15:0] x_start;
  reg [15:0] x_end;
  reg [15:0] y_mod_ctrl;
  reg [15:0] y_start;
  reg [15:0] y_end;
  reg [15:0] program_window_ctrl;
  reg [7:0] wrap_count;
  reg last_x_wrap;
  reg last_y_wrap;
  // Loop index for clearing the register file in reset
  integer i;

  // Step size: byte or word, sign by direction
  function [15:0] step_addr;
    input [15:0] base;
    input [2:0] modifier;
    input is_byte;
    reg [15:0] step;
    begin
      step = is_byte ? 16'h0001 : 16'h0002;
      case (modifier)
        `MOD_POSTINC, `MOD_PREINC: step_addr = base + step;
        `MOD_POSTDEC, `MOD_PREDEC: step_addr = base - step;
        default: step_addr = base;
      endcase
    end
  endfunction

  function is_dec;
    input [2:0] modifier;
    begin
      is_dec = (modifier == `MOD_POSTDEC) || (modifier == `MOD_PREDEC);
    end
  endfunction

  // Pre-modify forms use the stepped pointer as the address itself
  function is_pre;
    input [2:0] modifier;
    begin
      is_pre = (modifier == `MOD_PREINC) || (modifier == `MOD_PREDEC);
    end
  endfunction

  // Pre or post modify: the only forms whose corrected value goes back to the pointer
  function is_modify;
    input [2:0] modifier;
    begin
      is_modify = (modifier == `MOD_POSTINC) || (modifier == `MOD_POSTDEC) || is_pre(modifier);
    end
  endfunction

  // X generator: effective address before correction
  // Modes other than indirect ignore the modifier, so their pointer never moves
  // Illegal mode codes still form an address, but raise the error flag instead of valid
  reg [15:0] x_ptr;
  reg [15:0] x_stepped;
  reg [15:0] x_raw_ea;
  reg x_legal;
  always @* begin
    x_ptr = wreg[x_reg_i];
    x_stepped = step_addr(x_ptr, x_modifier_i, x_byte_i);
    x_legal = 1'b1;
    case (x_mode_i)
      `AM_DIRECT: x_raw_ea = x_literal_i;
      `AM_LITERAL, `AM_INHERENT, `AM_RELATIVE, `AM_REGDIRECT: x_raw_ea = x_ptr;
      `AM_INDIRECT: begin
        case (x_modifier_i)
          `MOD_PREINC, `MOD_PREDEC: x_raw_ea = x_stepped;
          `MOD_OFFSET: x_raw_ea = x_ptr + wreg[x_offset_reg_i];
          default: x_raw_ea = x_ptr;
        endcase
      end
      default: begin
        x_raw_ea = x_ptr;
        x_legal = 1'b0;
      end
    endcase
  end

  // Correction applies to whichever pointer the control register selects
  // One circular pointer per generator: the select field names a single register
  wire x_mod_hit = x_mod_ctrl[`MOD_EN_BIT] && (x_mod_ctrl[3:0] == x_reg_i) &&
                   (x_mode_i == `AM_INDIRECT);
  wire y_mod_hit = y_mod_ctrl[`MOD_EN_BIT] && (y_mod_ctrl[3:0] == y_reg_i);
  wire [15:0] x_ea;
  wire [15:0] x_wb;
  wire x_wrap_ea;
  wire x_wrap_wb;

  modulo_corrector #(.AW(16)) x_corr_ea (
    .enable_i(x_mod_hit),
    .decrement_i(is_dec(x_modifier_i)),
    .start_i(x_start),
    .end_i(x_end),
    .addr_i(x_raw_ea),
    .addr_o(x_ea),
    .wrapped_o(x_wrap_ea)
  );

  // Post-modify pointer value gets its own correction
  modulo_corrector #(.AW(16)) x_corr_wb (
    .enable_i(x_mod_hit),
    .decrement_i(is_dec(x_modifier_i)),
    .start_i(x_start),
    .end_i(x_end),
    .addr_i(x_stepped),
    .addr_o(x_wb),
    .wrapped_o(x_wrap_wb)
  );

  // Y generator: indirect post/pre modify only, dual operand reads
  // Y steps by whole words only, even when x_byte_i marks a byte operand on the dual-read path
  wire [15:0] y_ptr = wreg[y_reg_i];
  wire [15:0] y_stepped = step_addr(y_ptr, y_modifier_i, 1'b0);
  wire y_pre = is_pre(y_modifier_i);
  wire [15:0] y_ea;
  wire [15:0] y_wb;
  wire y_wrap_ea;

  modulo_corrector #(.AW(16)) y_corr_ea (
    .enable_i(y_mod_hit),
    .decrement_i(is_dec(y_modifier_i)),
    .start_i(y_start),
    .end_i(y_end),
    .addr_i(y_pre ? y_stepped : y_ptr),
    .addr_o(y_ea),
    .wrapped_o(y_wrap_ea)
  );

  modulo_corrector #(.AW(16)) y_corr_wb (
    .enable_i(y_mod_hit),
    .decrement_i(is_dec(y_modifier_i)),
    .start_i(y_start),
    .end_i(y_end),
    .addr_i(y_stepped),
    .addr_o(y_wb),
    .wrapped_o()
  );

  // Paging of the X address; Y only reaches the base space
  // Writes always page on EA bit 15; read page bit 9 turns a read into a program access
  wire [23:0] x_paged;
  wire x_program_window;
  page_mapper x_pager (
    .ea_i(x_ea),
    .is_write_i(x_write_i),
    .data_read_page_i(data_read_page),
    .data_write_page_i(data_write_page),
    .addr_o(x_paged),
    .program_space_window_o(x_program_window)
  );

  // Write-back qualifiers; plain indirect and register-plus-offset leave the pointer alone
  wire x_updates = x_req_i && x_legal && (x_mode_i == `AM_INDIRECT) &&
                   is_modify(x_modifier_i);
  wire y_active = y_req_i && x_dsp_class_i && !x_write_i;
  wire y_updates = y_active && is_modify(y_modifier_i);

  // APB decode; zero wait states
  // The error response only rises in the access phase, so a setup cycle never looks like an error
  wire apb_wr = psel_i && penable_i && pwrite_i;
  wire wreg_hit = (paddr_i >= `OFS_WREG_BASE) && (paddr_i <= `OFS_WREG_LAST);
  wire [3:0] wreg_idx = paddr_i[5:2];
  wire mapped = wreg_hit || (paddr_i <= `OFS_Y_END) || (paddr_i == `OFS_STATUS) ||
                (paddr_i == `OFS_PROGRAM_WINDOW_CTRL);
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && (!mapped || paddr_i[1:0] != 2'b00);

  // Working register file with pointer write-back and stack
  // Later assignments win: APB, then direct write, then X and Y write-back, then the stack
  // A push or pop therefore overrides any other write to the stack pointer in that cycle
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      for (i = 0; i < NREG; i = i + 1) begin
        wreg[i] <= 16'h0000;
      end
      wreg[NREG-1] <= `RST_STACK;
    end else begin
      if (apb_wr && wreg_hit && paddr_i[1:0] == 2'b00) begin
        wreg[wreg_idx] <= pwdata_i[15:0];
      end
      if (wreg_we_i) begin
        wreg[wreg_sel_i] <= wreg_data_i;
      end
      if (x_updates) begin
        wreg[x_reg_i] <= x_wb;
      end
      if (y_updates) begin
        wreg[y_reg_i] <= y_wb;
      end
      if (stack_push_i) begin
        wreg[NREG-1] <= wreg[NREG-1] + 16'h0002;
      end else if (stack_pop_i) begin
        wreg[NREG-1] <= wreg[NREG-1] - 16'h0002;
      end
    end
  end

  // Control registers
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      data_read_page <= `RST_READ_PAGE;
      data_write_page <= `RST_WRITE_PAGE;
      x_mod_ctrl <= 16'h0000;
      x_start <= 16'h0000;
      x_end <= 16'h0000;
      y_mod_ctrl <= 16'h0000;
      y_start <= 16'h0000;
      y_end <= 16'h0000;
      program_window_ctrl <= 16'h0000;
    end else if (apb_wr) begin
      // Page registers keep only their implemented widths; upper write data is dropped
      case (paddr_i)
        `OFS_READ_PAGE: data_read_page <= pwdata_i[9:0];
        `OFS_WRITE_PAGE: data_write_page <= pwdata_i[8:0];
        `OFS_X_MOD_CTRL: x_mod_ctrl <= pwdata_i[15:0];
        `OFS_X_START: x_start <= pwdata_i[15:0];
        `OFS_X_END: x_end <= pwdata_i[15:0];
        `OFS_Y_MOD_CTRL: y_mod_ctrl <= pwdata_i[15:0];
        `OFS_Y_START: y_start <= pwdata_i[15:0];
        `OFS_Y_END: y_end <= pwdata_i[15:0];
        `OFS_PROGRAM_WINDOW_CTRL: program_window_ctrl <= pwdata_i[15:0];
        // Status is read-only, so writes to it land here and change nothing
        default: program_window_ctrl <= program_window_ctrl;
      endcase
    end
  end

  // Read data registered at the setup phase so it is stable in access
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      prdata_o <= 32'h00000000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      if (wreg_hit) begin
        prdata_o <= {16'h0000, wreg[wreg_idx]};
      end else begin
        case (paddr_i)
          `OFS_READ_PAGE: prdata_o <= {22'h0, data_read_page};
          `OFS_WRITE_PAGE: prdata_o <= {23'h0, data_write_page};
          `OFS_X_MOD_CTRL: prdata_o <= {16'h0000, x_mod_ctrl};
          `OFS_X_START: prdata_o <= {16'h0000, x_start};
          `OFS_X_END: prdata_o <= {16'h0000, x_end};
          `OFS_Y_MOD_CTRL: prdata_o <= {16'h0000, y_mod_ctrl};
          `OFS_Y_START: prdata_o <= {16'h0000, y_start};
          `OFS_Y_END: prdata_o <= {16'h0000, y_end};
          // Status: bit 10 mode error, bit 9 last Y wrap, bit 8 last X wrap, bits 7:0 wrap count
          `OFS_STATUS: prdata_o <= {21'h0, mode_error_o, last_y_wrap, last_x_wrap, wrap_count};
          `OFS_PROGRAM_WINDOW_CTRL: prdata_o <= {16'h0000, program_window_ctrl};
          default: prdata_o <= 32'h00000000;
        endcase
      end
    end
  end

  // Address outputs and status, one cycle after the request
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      x_valid_o <= 1'b0;
      x_write_o <= 1'b0;
      x_addr_o <= 24'h000000;
      x_program_space_o <= 1'b0;
      y_valid_o <= 1'b0;
      y_addr_o <= 16'h0000;
      mode_error_o <= 1'b0;
      wrap_count <= 8'h00;
      last_x_wrap <= 1'b0;
      last_y_wrap <= 1'b0;
    end else begin
      x_valid_o <= x_req_i && x_legal;
      x_write_o <= x_write_i;
      x_addr_o <= x_paged;
      // The window control bit forces program space for any upper-half address
      x_program_space_o <= x_program_window || (program_window_ctrl[0] && x_ea[15]);
      // Both operands leave in the same cycle so a dual read issues as one access
      y_valid_o <= y_active;
      y_addr_o <= y_ea;
      mode_error_o <= x_req_i && !x_legal;
      // Wrap count rolls over after 255; it is a debug aid, not an exact event log
      if (x_req_i && (x_wrap_ea || x_wrap_wb)) begin
        wrap_count <= wrap_count + 8'h01;
      end
      last_x_wrap <= x_req_i && (x_wrap_ea || x_wrap_wb);
      last_y_wrap <= y_active && y_wrap_ea;
    end
  end
endmodule

//--- adgu_sva.sv
// Port-level assertions for the data address generation unit
`timescale 1ns/1ps
`include "agu_map.vh"
module adgu_sva (
  input wire clock_i,
  input wire rstn_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire x_req_i,
  input wire x_write_i,
  input wire x_dsp_class_i,
  input wire [2:0] x_mode_i,
  input wire [15:0] x_literal_i,
  input wire y_req_i,
  input wire x_valid_o,
  input wire x_write_o,
  input wire [23:0] x_addr_o,
  input wire x_program_space_o,
  input wire y_valid_o,
  input wire mode_error_o
);
  reg [8:0] rpage;
  reg rpage_hi;
  reg [8:0] wpage;
  reg window_force;
  wire apb_wr = psel_i && penable_i && pwrite_i;
  wire [14:0] lit_low = x_literal_i[14:0];
  wire y_act = y_req_i && x_dsp_class_i && !x_write_i;
  // Shadow page and window registers; written only at the APB access edge
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      {rpage_hi, rpage} <= `RST_READ_PAGE;
      wpage <= `RST_WRITE_PAGE;
      window_force <= 1'b0;
    end else if (apb_wr && paddr_i == `OFS_READ_PAGE) begin
      {rpage_hi, rpage} <= pwdata_i[9:0];
    end else if (apb_wr && paddr_i == `OFS_WRITE_PAGE) begin
      wpage <= pwdata_i[8:0];
    end else if (apb_wr && paddr_i == `OFS_PROGRAM_WINDOW_CTRL) begin
      window_force <= pwdata_i[0];
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  sequence s_dir_rd;
    x_req_i && x_mode_i == `AM_DIRECT && !x_write_i && x_literal_i[15];
  endsequence
  sequence s_dir_wr;
    x_req_i && x_mode_i == `AM_DIRECT && x_write_i && x_literal_i[15];
  endsequence
  a_read_page: assert property (s_dir_rd |=> x_valid_o && x_addr_o == {$past(rpage), $past(lit_low)})
    else $error("read page not placed over the address");
  a_program_flag: assert property (s_dir_rd |=> x_program_space_o == ($past(rpage_hi) || $past(window_force)))
    else $error("program space flag wrong");
  a_write_page: assert property (s_dir_wr |=> x_write_o && x_addr_o == {$past(wpage), $past(lit_low)})
    else $error("write page not placed over the address");
  a_base_direct: assert property (x_req_i && x_mode_i == `AM_DIRECT && !x_literal_i[15]
    |=> x_valid_o && !x_program_space_o && x_addr_o == {8'h00, $past(x_literal_i)})
    else $error("base address was paged");
  a_err_set: assert property (x_req_i && x_mode_i > `AM_INDIRECT |=> mode_error_o && !x_valid_o)
    else $error("illegal mode not refused");
  a_err_cause: assert property (mode_error_o |-> $past(x_req_i) && $past(x_mode_i) > `AM_INDIRECT)
    else $error("mode error without illegal request");
  a_x_cause: assert property (x_valid_o |-> $past(x_req_i))
    else $error("x access without request");
  a_y_cause: assert property (y_valid_o |-> $past(y_act))
    else $error("y access without dual read");
endmodule
bind data_address_generation_unit adgu_sva chk (.clock_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .x_req_i, .x_write_i, .x_dsp_class_i, .x_mode_i, .x_literal_i, .y_req_i, .x_valid_o, .x_write_o,
  .x_addr_o, .x_program_space_o, .y_valid_o, .mode_error_o);

//--- mem_port_model.sv
// Far-side memory port model that tallies X and Y accesses
`timescale 1ns/1ps
module mem_port_model (
  input wire clock_i,
  input wire rstn_i,
  input wire x_valid_i,
  input wire y_valid_i,
  output reg [15:0] x_count_o,
  output reg [15:0] y_count_o
);
  // The ports carry strobes with no stall path, so the memory can only count them
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      x_count_o <= 16'h0000;
      y_count_o <= 16'h0000;
    end else begin
      x_count_o <= x_count_o + {15'h0000, x_valid_i};
      y_count_o <= y_count_o + {15'h0000, y_valid_i};
    end
  end
endmodule

//--- data_address_generation_unit_tb.sv
// Self-checking bench for the data address generation unit
`timescale 1ns/1ps
`include "agu_map.vh"
module data_address_generation_unit_tb;
  logic clock_i = 0, rstn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, x_req_i = 0, x_write_i = 0;
  logic x_dsp_class_i = 0, x_byte_i = 0, y_req_i = 0, stack_push_i = 0, stack_pop_i = 0, wreg_we_i = 0, w;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0;
  logic [2:0] x_mode_i = 0, x_modifier_i = 0, y_modifier_i = 0;
  logic [3:0] x_reg_i = 0, x_offset_reg_i = 0, y_reg_i = 0, wreg_sel_i = 0;
  logic [15:0] x_literal_i = 0, wreg_data_i = 0, lit, xc, yc, nx = 0, ny = 0;
  logic [9:0] rp = 10'h001;
  logic [8:0] wp = 9'h001;
  logic [32:0] xq[$], yq[$], rq[$];
  wire pready_o, pslverr_o, x_valid_o, x_write_o, x_program_space_o, y_valid_o, mode_error_o;
  wire [31:0] prdata_o;
  wire [23:0] x_addr_o;
  wire [15:0] y_addr_o;
  int bad_count = 0, n_tests = 0, seed = 32'ha23234aa, i, k;
  data_address_generation_unit uut (.*);
  mem_port_model mem (.clock_i, .rstn_i, .x_valid_i(x_valid_o), .y_valid_i(y_valid_o), .x_count_o(xc), .y_count_o(yc));
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  // Expected X result: paging applies only when the address has its top bit set
  function automatic logic [26:0] ex(input logic wr, input logic [15:0] ea);
    ex = {1'b0, ea[15] && !wr && rp[9], wr, ea[15] ? {wr ? wp : rp[8:0], ea[14:0]} : {8'h00, ea}};
  endfunction
  task automatic chk(input logic [32:0] g, input logic [32:0] e, input string s);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, s, g, e);
    end
  endtask
  // APB master; a read note with bit 32 set expects only the error response
  task automatic apb(input logic wr, input logic [11:0] a, input logic [32:0] d);
    @(posedge clock_i);
    {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, wr, a, d[31:0]};
    if (!wr) rq.push_back(d);
    @(posedge clock_i);
    penable_i <= 1;
    do @(posedge clock_i); while (pready_o !== 1'b1);
    {psel_i, penable_i} <= 2'b00;
  endtask
  task automatic wset(input logic [3:0] r, input logic [15:0] v);
    @(posedge clock_i);
    {wreg_we_i, wreg_sel_i, wreg_data_i} <= {1'b1, r, v};
    @(posedge clock_i);
    wreg_we_i <= 0;
  endtask
  task automatic xop(input logic [2:0] m, input logic [2:0] md, input logic [3:0] r, input logic [26:0] e, input logic y);
    @(posedge clock_i);
    {x_req_i, x_mode_i, x_modifier_i, x_reg_i, x_write_i, y_req_i} <= {1'b1, m, md, r, e[24], y};
    xq.push_back(e);
    nx += !e[26];
    @(posedge clock_i);
    {x_req_i, y_req_i} <= 2'b00;
  endtask
  task automatic stk(input logic push, input logic [15:0] e);
    @(posedge clock_i);
    {stack_push_i, stack_pop_i} <= {push, !push};
    @(posedge clock_i);
    {stack_push_i, stack_pop_i} <= 2'b00;
    apb(0, `OFS_WREG_LAST, e);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Results are taken at the next rising edge, while they still stand; read data at the access edge
  always @(posedge clock_i) begin
    if (x_valid_o || mode_error_o)
      chk(mode_error_o ? 33'h4000000 : {7'h00, x_program_space_o, x_write_o, x_addr_o}, xq.pop_front(), "x");
    if (y_valid_o)
      chk({17'h0, y_addr_o}, yq.pop_front(), "y");
    if (psel_i && penable_i && !pwrite_i)
      chk({pslverr_o, rq[0][32] ? 32'h0 : prdata_o}, rq.pop_front(), "apb");
  end
  // Watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    #50000;
    bad_count++;
    test_done;
  end
  initial begin
    repeat (5) @(posedge clock_i);
    rstn_i <= 1;
    apb(0, `OFS_READ_PAGE, 33'h001);
    apb(0, `OFS_WRITE_PAGE, 33'h001);
    apb(0, `OFS_WREG_LAST, 33'h1000);
    apb(0, 12'h0FC, 33'h100000000);
    stk(1, 16'h1002);
    stk(0, 16'h1000);
    $display("test reset and stack done");
    wp = 9'h003;
    apb(1, `OFS_WRITE_PAGE, 33'h003);
    // Back-to-back random direct reads and writes, first as plain data then with program flag on reads
    for (k = 0; k < 2; k++) begin
      rp = k ? 10'h205 : 10'h005;
      apb(1, `OFS_READ_PAGE, {23'h0, rp});
      for (i = 0; i < 16; i++) begin
        @(posedge clock_i);
        lit = 16'($random(seed));
        w = 1'($random(seed));
        {x_req_i, x_mode_i, x_write_i, x_literal_i} <= {1'b1, `AM_DIRECT, w, lit};
        xq.push_back(ex(w, lit));
        nx++;
      end
      @(posedge clock_i);
      x_req_i <= 0;
    end
    // Forced program window: an upper-half data read is flagged as program space
    rp = 10'h005;
    apb(1, `OFS_READ_PAGE, {23'h0, rp});
    apb(1, `OFS_PROGRAM_WINDOW_CTRL, 33'h001);
    x_literal_i <= 16'h8004;
    xop(`AM_DIRECT, `MOD_NONE, 0, ex(0, 16'h8004) | 27'h2000000, 0);
    apb(1, `OFS_PROGRAM_WINDOW_CTRL, 33'h000);
    $display("test paging done");
    apb(1, `OFS_X_MOD_CTRL, 33'h8003);
    apb(1, `OFS_X_START, 33'h1000);
    apb(1, `OFS_X_END, 33'h100F);
    wset(3, 16'h100E);
    xop(`AM_INDIRECT, `MOD_POSTINC, 3, ex(0, 16'h100E), 0);
    apb(0, 12'h04C, 33'h1000);
    wset(3, 16'h1000);
    xop(`AM_INDIRECT, `MOD_PREDEC, 3, ex(0, 16'h100E), 0);
    apb(0, 12'h04C, 33'h100E);
    wset(3, 16'h1008);
    wset(5, 16'h000A);
    x_offset_reg_i <= 5;
    xop(`AM_INDIRECT, `MOD_OFFSET, 3, ex(0, 16'h1002), 0);
    apb(0, 12'h04C, 33'h1008);
    wset(4, 16'h0200);
    x_byte_i <= 1;
    xop(`AM_INDIRECT, `MOD_POSTINC, 4, ex(0, 16'h0200), 0);
    x_byte_i <= 0;
    apb(0, 12'h050, 33'h0201);
    apb(0, `OFS_STATUS, 33'h003);
    $display("test circular done");
    apb(1, `OFS_Y_MOD_CTRL, 33'h8006);
    apb(1, `OFS_Y_START, 33'h2000);
    apb(1, `OFS_Y_END, 33'h2007);
    wset(6, 16'h2006);
    wset(2, 16'h0100);
    {y_modifier_i, y_reg_i, x_dsp_class_i} <= {`MOD_POSTINC, 4'h6, 1'b1};
    yq.push_back(33'h2006);
    ny++;
    xop(`AM_INDIRECT, `MOD_NONE, 2, ex(0, 16'h0100), 1);
    x_dsp_class_i <= 0;
    apb(0, 12'h058, 33'h2000);
    xop(`AM_REGDIRECT, `MOD_POSTINC, 2, ex(0, 16'h0100), 0);
    apb(0, 12'h048, 33'h0100);
    xop(3'h6, `MOD_NONE, 0, 27'h4000000, 0);
    xop(3'h7, `MOD_NONE, 0, 27'h4000000, 0);
    repeat (2) @(posedge clock_i);
    chk({17'h0, xc}, {17'h0, nx}, "x count");
    chk({17'h0, yc}, {17'h0, ny}, "y count");
    $display("test dual and refusal done");
    test_done;
  end
endmodule
